// file: dv/motion_wake_top_tb.sv
`timescale 1ns/10ps
`include "motion_wake_map.svh"
module motion_wake_top_tb;
  localparam logic [7:0] A_TD = {`IDX_THRESHOLD_DATA, 2'b00};
  localparam logic [7:0] A_CFG = {`IDX_MOTION_CFG, 2'b00};
  localparam logic [7:0] A_ST = {`IDX_IRQ_STATUS, 2'b00};
  localparam logic [7:0] A_MSK = {`IDX_IRQ_MASK, 2'b00};
  localparam logic [7:0] A_WK = {`IDX_WAKE_STATUS, 2'b00};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sample_valid = 1'b0;
  logic signed [11:0] sample_x = 12'sh000;
  logic signed [11:0] sample_y = 12'sh000;
  logic signed [11:0] sample_z = 12'sh000;
  logic irq;
  logic wakeup;
  logic [31:0] rdat;
  logic rerr;
  int err_total = 0;
  int n_compared = 0;

  always #12.5 pclk = ~pclk;

  motion_wake_top #(.SW(12)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_valid(sample_valid), .sample_x(sample_x), .sample_y(sample_y), .sample_z(sample_z),
    .irq(irq), .wakeup(wakeup));

  // ********************
  // Bus and compare tasks
  // ********************
  task chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t register got %h expected %h", $time, got, exp);
    end
  endtask

  task chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t flag got %b expected %b", $time, got, exp);
    end
  endtask

  // The request stands until pready is seen high at a rising edge; data is taken at that edge.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20) begin
      err_total++;
      $display("[FAIL] %0t no bus answer", $time);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rdat, rerr);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    apb(1'b0, a, 32'h0, rdat, rerr);
    chk_reg(rdat, exp);
    chk_bit(rerr, exp_err);
  endtask

  task cfg(input logic [2:0] sel, input logic cen, input logic [2:0] slc, input logic rst);
    wr(A_CFG, {24'h0, rst, slc, cen, sel});
  endtask

  task send(input logic signed [11:0] x);
    @(posedge pclk);
    sample_valid <= 1'b1;
    sample_x <= x;
    @(posedge pclk);
    sample_valid <= 1'b0;
    repeat (5) @(posedge pclk);
  endtask

  task wake_x(input logic exp);
    apb(1'b0, A_WK, 32'h0, rdat, rerr);
    chk_bit(rdat[0], exp);
  endtask

  task chk_irq(input logic exp);
    @(negedge pclk);
    chk_bit(irq, exp);
  endtask

  task probe(input logic [2:0] code, input logic signed [11:0] d, input logic exp);
    cfg(3'h1, 1'b0, code, 1'b1);
    wr(A_TD, 32'h08);
    cfg(3'h1, 1'b0, code, 1'b0);
    send(12'sh000);
    send(d);
    wake_x(exp);
    chk_bit(wakeup, exp);
  endtask

  // ********************
  // Scenarios
  // ********************
  task test_regs;
    rdc(A_CFG, 32'h0, 1'b0);
    rdc(A_TD, 32'h0, 1'b0);
    rdc(A_ST, 32'h0, 1'b0);
    rdc(A_MSK, 32'h0, 1'b0);
    wr(A_CFG, 32'hFF);
    apb(1'b1, 8'h51, 32'h00, rdat, rerr);
    chk_bit(rerr, 1'b1);
    repeat (8) @(posedge pclk);
    rdc(A_CFG, 32'hFF, 1'b0);
    rdc(8'h70, 32'h0, 1'b1);
    $display("test_regs done");
  endtask

  task test_shadow;
    for (int s = 1; s < 8; s++) if (s != 4) begin
      cfg(3'(s), 1'b0, 3'h0, 1'b1);
      wr(A_TD, 32'(s * 9));
    end
    cfg(3'h0, 1'b0, 3'h0, 1'b1);
    wr(A_TD, 32'h3F);
    cfg(3'h4, 1'b0, 3'h0, 1'b1);
    wr(A_TD, 32'h3F);
    for (int s = 1; s < 8; s++) if (s != 4) begin
      cfg(3'(s), 1'b0, 3'h0, 1'b1);
      rdc(A_TD, 32'(s * 9), 1'b0);
    end
    $display("test_shadow done");
  endtask

  // The third probe only fires if the slice clamps; a wrapped slice would read zero.
  task test_slice;
    int sh;
    for (int c = 0; c < 8; c++) begin
      sh = (c > 4) ? 5 : c;
      probe(3'(c), 12'(8 << sh), 1'b1);
      probe(3'(c), 12'(7 << sh), 1'b0);
      if (c < 5) probe(3'(c), 12'(-(64 << sh)), 1'b1);
    end
    $display("test_slice done");
  endtask

  task test_count;
    cfg(3'h5, 1'b1, 3'h0, 1'b1);
    wr(A_TD, 32'h02);
    cfg(3'h1, 1'b1, 3'h0, 1'b1);
    wr(A_TD, 32'h08);
    cfg(3'h1, 1'b1, 3'h0, 1'b0);
    send(12'sh000);
    send(12'sh008);
    send(12'sh000);
    wake_x(1'b0);
    send(12'sh008);
    wake_x(1'b1);
    cfg(3'h1, 1'b1, 3'h0, 1'b1);
    repeat (3) @(negedge pclk);
    chk_bit(wakeup, 1'b0);
    rdc(A_CFG, 32'h89, 1'b0);
    $display("test_count done");
  endtask

  task test_modes;
    for (int m = 0; m < 2; m++) begin
      cfg(3'h0, 1'b0, 3'h0, 1'b1);
      wr(A_TD, {24'h0, 1'(m), 7'h00});
      cfg(3'h1, 1'b0, 3'h0, 1'b0);
      send(12'sh000);
      send(12'sh006);
      send(12'sh00C);
      wake_x(1'(m));
    end
    cfg(3'h0, 1'b0, 3'h0, 1'b1);
    wr(A_TD, 32'h40);
    cfg(3'h0, 1'b0, 3'h0, 1'b0);
    send(12'sh000);
    send(12'sh008);
    wake_x(1'b1);
    chk_bit(wakeup, 1'b0);
    wr(A_TD, 32'h00);
    repeat (3) @(negedge pclk);
    chk_bit(wakeup, 1'b1);
    $display("test_modes done");
  endtask

  task test_irq;
    cfg(3'h1, 1'b0, 3'h0, 1'b1);
    cfg(3'h1, 1'b0, 3'h0, 1'b0);
    wr(A_MSK, 32'h0);
    wr(A_ST, 32'h3);
    rdc(A_ST, 32'h0, 1'b0);
    send(12'sh000);
    send(12'sh008);
    rdc(A_ST, 32'h3, 1'b0);
    chk_irq(1'b0);
    wr(A_MSK, 32'h2);
    chk_irq(1'b1);
    wr(A_ST, 32'h2);
    chk_irq(1'b0);
    rdc(A_ST, 32'h1, 1'b0);
    wr(A_MSK, 32'h1);
    chk_irq(1'b1);
    wr(A_ST, 32'h1);
    chk_irq(1'b0);
    $display("test_irq done");
  endtask

  task finish_test;
    $display("Comparisons %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    test_regs;
    test_shadow;
    test_slice;
    test_count;
    test_modes;
    test_irq;
    finish_test;
  end

  // The whole run needs about a thousand cycles; forty times that means a hang.
  initial begin
    repeat (40000) @(posedge pclk);
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test;
  end
endmodule

// file: hw/axis_detect.sv
`timescale 1ns/10ps
`include "motion_wake_map.svh"
module axis_detect #(parameter int SW = 12) (
  input wire logic pclk,
  input wire logic presetn,
  axis_link_if.det lnk
);
  import motion_wake_pkg::*;

  // ****************************************************************
  // Delta, slice and event counter.
  // ****************************************************************
  det_state_t state_q, state_d;
  logic signed [SW-1:0] ref_q, ref_d;
  six_t ev_cnt_q, ev_cnt_d;
  logic evt_q, evt_d;
  logic signed [SW:0] diff;
  logic [SW:0] mag;
  logic [10:0] delta;
  six_t slice;
  logic hit;

  function automatic six_t pick_slice(input logic [10:0] d, input logic [2:0] sel);
    logic [2:0] sh;
    logic [10:0] s;
    sh = (sel > `SLICE_TOP_CODE) ? `SLICE_TOP_CODE : sel;
    s = d >> sh;
    // Anything above the window saturates so a large motion is never lost.
    return (|s[10:6]) ? 6'h3F : s[5:0];
  endfunction

  always_comb begin
    diff = {lnk.sample[SW-1], lnk.sample} - {ref_q[SW-1], ref_q};
    mag = diff[SW] ? $unsigned(-diff) : $unsigned(diff);
    delta = (|mag[SW:11]) ? 11'h7FF : mag[10:0];
    slice = pick_slice(delta, lnk.slice_sel);
    hit = (slice >= lnk.threshold);
    state_d = state_q;
    ref_d = ref_q;
    ev_cnt_d = ev_cnt_q;
    evt_d = 1'b0;
    if (lnk.det_reset) begin
      state_d = DET_EMPTY;
      ev_cnt_d = `SHADOW_RESET_VAL;
    end else if (lnk.sample_valid) begin
      case (state_q)
        DET_EMPTY: begin
          ref_d = lnk.sample;
          state_d = DET_RUN;
        end
        DET_RUN: begin
          if (!lnk.delta_mode) begin
            ref_d = lnk.sample;
          end
          evt_d = hit;
          if (hit && ev_cnt_q != `COUNT_MAX) begin
            ev_cnt_d = ev_cnt_q + 6'h01;
          end
        end
        default: begin
          state_d = DET_EMPTY;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= DET_EMPTY;
      ref_q <= '0;
      ev_cnt_q <= `SHADOW_RESET_VAL;
      evt_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ref_q <= ref_d;
      ev_cnt_q <= ev_cnt_d;
      evt_q <= evt_d;
    end
  end

  assign lnk.evt = evt_q;
  // Stored count is events minus one; without counters one event is enough.
  assign lnk.qual = lnk.cnt_en ? (ev_cnt_q > lnk.count) : (ev_cnt_q != 6'h00);

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_c2p_ref_follow: assert property (lnk.sample_valid && state_q == DET_RUN && !lnk.delta_mode && !lnk.det_reset
    |=> ref_q == $past(lnk.sample)) else $error("previous sample not kept");
  a_c2b_ref_hold: assert property (lnk.sample_valid && state_q == DET_RUN && lnk.delta_mode && !lnk.det_reset
    |=> $stable(ref_q)) else $error("baseline moved");
  a_event_counts: assert property (lnk.sample_valid && state_q == DET_RUN && !lnk.det_reset && hit
    && ev_cnt_q < `COUNT_MAX |=> ev_cnt_q == $past(ev_cnt_q) + 6'h01 && evt_q) else $error("event not counted");
  a_slice_clamp: assert property (lnk.slice_sel == 3'h0 && |delta[10:6] |-> slice == 6'h3F)
    else $error("slice not clamped");
  a_det_reset_clears: assert property (lnk.det_reset |=> ev_cnt_q == 6'h00 && state_q == DET_EMPTY)
    else $error("detector not held in reset");
endmodule

// file: hw/axis_link_if.sv
`timescale 1ns/10ps
interface axis_link_if #(parameter int SW = 12);
  import motion_wake_pkg::*;
  six_t threshold;
  six_t count;
  logic [2:0] slice_sel;
  logic cnt_en;
  logic delta_mode;
  logic det_reset;
  logic sample_valid;
  logic signed [SW-1:0] sample;
  logic evt;
  logic qual;
  modport cfg (output threshold, count, slice_sel, cnt_en, delta_mode, det_reset, sample_valid, sample,
               input evt, qual);
  modport det (input threshold, count, slice_sel, cnt_en, delta_mode, det_reset, sample_valid, sample,
               output evt, qual);
endinterface

// file: hw/motion_wake_map.svh
`ifndef MOTION_WAKE_MAP_SVH
`define MOTION_WAKE_MAP_SVH
// ****************************************************************
// Register indices; the byte address is four times the index.
// ****************************************************************
`define IDX_THRESHOLD_DATA 6'h13
`define IDX_MOTION_CFG 6'h14
`define IDX_IRQ_STATUS 6'h18
`define IDX_IRQ_MASK 6'h19
`define IDX_WAKE_STATUS 6'h1A
// ****************************************************************
// Field positions and reset values.
// ****************************************************************
`define CFG_SEL_LSB 0
`define CFG_CNTEN_BIT 3
`define CFG_SLICE_LSB 4
`define CFG_DETRST_BIT 7
`define TD_COMBINE_BIT 6
`define TD_DMODE_BIT 7
`define CFG_RESET_VAL 8'h00
`define TD_RESET_VAL 2'h0
`define SHADOW_RESET_VAL 6'h00
`define IRQ_WAKE_BIT 0
`define IRQ_EVENT_BIT 1
`define SLICE_TOP_CODE 3'h5
`define COUNT_MAX 6'h3F
`endif

// file: hw/motion_wake_pkg.sv
package motion_wake_pkg;
  typedef logic [5:0] six_t;
  typedef enum logic [1:0] {
    DET_EMPTY = 2'b00,
    DET_RUN = 2'b01
  } det_state_t;
endpackage

// file: hw/motion_wake_top.sv
// How it works
// - The threshold data register reaches the shadow chosen by the select field: 1-3 thresholds, 5-7 counts, 0 and 4 none.
// - The counter enable bit, default 0, leaves the event counters unused; at 1 they gate the wakeup for all axes.
// - The slice field picks delta bits [5:0] up to [9:4] for codes 0-4 and bits [10:5] for codes 5-7.
// - A delta larger than the chosen window clamps to all ones so it still counts as a detection.
// - The detector reset bit 7 holds the detector in reset while set, defaults to 0 and is never cleared by hardware.
// - Each axis threshold is an independent 6-bit unsigned value.
// - Each axis count holds the wanted number of events minus one.
// - The combine bit picks any qualified axis (0) or all axes (1) for a wakeup.
// - The delta mode bit compares against the previous sample (0) or the captured baseline (1).
`timescale 1ns/10ps
`include "motion_wake_map.svh"
module motion_wake_top #(parameter int SW = 12) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sample_valid,
  input wire logic signed [SW-1:0] sample_x,
  input wire logic signed [SW-1:0] sample_y,
  input wire logic signed [SW-1:0] sample_z,
  output logic irq,
  output logic wakeup
);
  import motion_wake_pkg::*;

  // ****************************************************************
  // Register state.
  // ****************************************************************
  logic [7:0] cfg_q, cfg_d;
  logic [1:0] td_hi_q, td_hi_d;
  six_t th_q [3];
  six_t th_d [3];
  six_t cnt_q [3];
  six_t cnt_d [3];
  logic [1:0] irq_st_q, irq_st_d;
  logic [1:0] irq_mask_q, irq_mask_d;
  logic wake_q, wake_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic irq_q, irq_d;

  logic [2:0] qual;
  logic [2:0] evt;
  logic comb_wake;
  logic [5:0] idx;
  logic hit_td, hit_cfg, hit_st, hit_mask, hit_wake, mapped;
  logic access, done, wr;
  logic [2:0] sel;
  logic [1:0] sel_axis;
  logic sel_valid;
  logic [SW-1:0] samples [3];

  assign samples[0] = sample_x;
  assign samples[1] = sample_y;
  assign samples[2] = sample_z;

  // ****************************************************************
  // Per-axis detectors.
  // ****************************************************************
  for (genvar a = 0; a < 3; a++) begin : g_axis
    axis_link_if #(.SW(SW)) lnk ();
    assign lnk.threshold = th_q[a];
    assign lnk.count = cnt_q[a];
    assign lnk.slice_sel = cfg_q[`CFG_SLICE_LSB +: 3];
    assign lnk.cnt_en = cfg_q[`CFG_CNTEN_BIT];
    assign lnk.delta_mode = td_hi_q[1];
    assign lnk.det_reset = cfg_q[`CFG_DETRST_BIT];
    assign lnk.sample_valid = sample_valid;
    assign lnk.sample = samples[a];
    assign qual[a] = lnk.qual;
    assign evt[a] = lnk.evt;
    axis_detect #(.SW(SW)) u_det (
      .pclk(pclk),
      .presetn(presetn),
      .lnk(lnk)
    );
  end

  wake_combine u_comb (
    .qual(qual),
    .combine_and(td_hi_q[0]),
    .wake(comb_wake)
  );

  // ****************************************************************
  // APB decode; answer comes one cycle into the access phase.
  // ****************************************************************
  always_comb begin
    idx = paddr[7:2];
    hit_td = (idx == `IDX_THRESHOLD_DATA);
    hit_cfg = (idx == `IDX_MOTION_CFG);
    hit_st = (idx == `IDX_IRQ_STATUS);
    hit_mask = (idx == `IDX_IRQ_MASK);
    hit_wake = (idx == `IDX_WAKE_STATUS);
    mapped = (paddr[1:0] == 2'h0) && (hit_td || hit_cfg || hit_st || hit_mask || hit_wake);
    access = psel && penable && !pready_q;
    done = psel && penable && pready_q;
    wr = done && pwrite && mapped;
    sel = cfg_q[`CFG_SEL_LSB +: 3];
    sel_axis = sel[1:0] - 2'h1;
    sel_valid = (sel[1:0] != 2'h0);
  end

  always_comb begin
    pready_d = access;
    pslverr_d = access && !mapped;
    prdata_d = prdata_q;
    if (access) begin
      prdata_d = 32'h0000_0000;
      if (mapped && !pwrite) begin
        case (1'b1)
          hit_td: begin
            prdata_d[7:6] = td_hi_q;
            if (sel_valid) begin
              prdata_d[5:0] = sel[2] ? cnt_q[sel_axis] : th_q[sel_axis];
            end
          end
          hit_cfg: prdata_d[7:0] = cfg_q;
          hit_st: prdata_d[1:0] = irq_st_q;
          hit_mask: prdata_d[1:0] = irq_mask_q;
          hit_wake: prdata_d[3:0] = {wake_q, qual};
          default: prdata_d = 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************************************
  // Register writes and shadow routing.
  // ****************************************************************
  always_comb begin
    cfg_d = cfg_q;
    td_hi_d = td_hi_q;
    irq_mask_d = irq_mask_q;
    for (int i = 0; i < 3; i++) begin
      th_d[i] = th_q[i];
      cnt_d[i] = cnt_q[i];
    end
    if (wr && hit_cfg) begin
      cfg_d = pwdata[7:0];
    end
    if (wr && hit_td) begin
      td_hi_d = {pwdata[`TD_DMODE_BIT], pwdata[`TD_COMBINE_BIT]};
      if (sel_valid) begin
        if (sel[2]) begin
          cnt_d[sel_axis] = pwdata[5:0];
        end else begin
          th_d[sel_axis] = pwdata[5:0];
        end
      end
    end
    if (wr && hit_mask) begin
      irq_mask_d = pwdata[1:0];
    end
  end

  // ****************************************************************
  // Wake latch and interrupt.
  // ****************************************************************
  always_comb begin
    // The wake stays latched until software pulses the detector reset.
    wake_d = cfg_q[`CFG_DETRST_BIT] ? 1'b0 : (wake_q || comb_wake);
    irq_st_d = irq_st_q;
    if (wr && hit_st) begin
      irq_st_d = irq_st_q & ~pwdata[1:0];
    end
    // A new event in the clearing cycle survives the write.
    if (!cfg_q[`CFG_DETRST_BIT] && comb_wake && !wake_q) begin
      irq_st_d[`IRQ_WAKE_BIT] = 1'b1;
    end
    if (|evt) begin
      irq_st_d[`IRQ_EVENT_BIT] = 1'b1;
    end
    irq_d = |(irq_st_d & irq_mask_d);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= `CFG_RESET_VAL;
      td_hi_q <= `TD_RESET_VAL;
      for (int i = 0; i < 3; i++) begin
        th_q[i] <= `SHADOW_RESET_VAL;
        cnt_q[i] <= `SHADOW_RESET_VAL;
      end
      irq_st_q <= 2'h0;
      irq_mask_q <= 2'h0;
      wake_q <= 1'b0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      irq_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      td_hi_q <= td_hi_d;
      for (int i = 0; i < 3; i++) begin
        th_q[i] <= th_d[i];
        cnt_q[i] <= cnt_d[i];
      end
      irq_st_q <= irq_st_d;
      irq_mask_q <= irq_mask_d;
      wake_q <= wake_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
      irq_q <= irq_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
  assign wakeup = wake_q;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_td_write;
    done && pwrite && hit_td && paddr[1:0] == 2'h0;
  endsequence

  a_apb_answer_slot: assert property (s_setup ##1 s_access |=> pready ##1 !pready)
    else $error("answer not in second access cycle");
  a_shadow_none: assert property (s_td_write and (sel[1:0] == 2'h0)
    |=> $stable(th_q[0]) && $stable(th_q[1]) && $stable(th_q[2]) && $stable(cnt_q[0])) else $error("none code wrote");
  a_shadow_route: assert property (s_td_write and (sel == 3'h5)
    |=> cnt_q[0] == $past(pwdata[5:0]) && $stable(th_q[0])) else $error("count x not routed");
  a_det_reset_sticky: assert property (cfg_q[7] && !(wr && hit_cfg) |=> cfg_q[7] && !wakeup)
    else $error("detector reset changed by hardware");
  a_combine_or: assert property (!td_hi_q[0] && qual[1] && !cfg_q[7] |=> wakeup)
    else $error("any axis did not wake");
  a_combine_and: assert property (td_hi_q[0] && !qual[2] && !wake_q |=> !wakeup)
    else $error("wake without all axes");
  a_wake_held: assert property (wakeup && !cfg_q[7] |=> wakeup)
    else $error("wake dropped without reset");
  a_irq_level: assert property (irq_st_q[0] && irq_mask_q[0] |-> irq)
    else $error("irq low with unmasked status");

  // ****************************************************************
  // Register and interrupt checks.
  // ****************************************************************
  sequence s_cfg_write;
    done && pwrite && hit_cfg && paddr[1:0] == 2'h0;
  endsequence
  sequence s_mask_write;
    done && pwrite && hit_mask && paddr[1:0] == 2'h0;
  endsequence
  sequence s_status_clear;
    done && pwrite && hit_st && paddr[1:0] == 2'h0;
  endsequence

  a_cfg_write_lands: assert property (s_cfg_write |=> cfg_q == $past(pwdata[7:0]))
    else $error("config write lost");
  a_mask_write_lands: assert property (s_mask_write |=> irq_mask_q == $past(pwdata[1:0]))
    else $error("mask write lost");
  a_status_w1c: assert property (s_status_clear and (!comb_wake && evt == 3'h0)
    |=> irq_st_q == ($past(irq_st_q) & ~$past(pwdata[1:0]))) else $error("status not cleared by one");
  a_set_beats_clear: assert property (s_status_clear and (evt != 3'h0) |=> irq_st_q[1])
    else $error("event lost under clear");
  a_bad_addr_err: assert property (access && !mapped |=> pready && pslverr)
    else $error("unmapped access without error");
  a_good_addr_ok: assert property (access && mapped |=> pready && !pslverr)
    else $error("mapped access with error");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_bad_write_ignored: assert property (done && pwrite && !mapped |=> $stable(cfg_q) && $stable(irq_mask_q))
    else $error("unmapped write changed a register");
  a_cfg_read_back: assert property (access && mapped && !pwrite && hit_cfg |=> prdata == {24'h000000, $past(cfg_q)})
    else $error("config read wrong");
  a_status_read_back: assert property (access && mapped && !pwrite && hit_st |=> prdata == {30'h0, $past(irq_st_q)})
    else $error("status read wrong");
  a_td_none_reads: assert property (access && mapped && !pwrite && hit_td && sel[1:0] == 2'h0
    |=> prdata[5:0] == 6'h00) else $error("none code read a shadow");
  a_shadow_thr_y: assert property (s_td_write and (sel == 3'h2)
    |=> th_q[1] == $past(pwdata[5:0]) && $stable(cnt_q[1])) else $error("threshold y not routed");
  a_shadow_cnt_z: assert property (s_td_write and (sel == 3'h7)
    |=> cnt_q[2] == $past(pwdata[5:0]) && $stable(th_q[2])) else $error("count z not routed");
  a_td_mode_bits: assert property (s_td_write |=> td_hi_q == $past(pwdata[7:6]))
    else $error("mode bits not written");
  a_irq_low: assert property ((irq_st_q & irq_mask_q) == 2'h0 |-> !irq)
    else $error("irq high with nothing unmasked");
  a_wake_rise_flag: assert property (!cfg_q[7] && comb_wake && !wake_q |=> irq_st_q[0] && wakeup)
    else $error("wake rise not flagged");
  a_reset_drops_wake: assert property (cfg_q[7] && wakeup |=> !wakeup)
    else $error("wake kept under detector reset");
endmodule

// file: hw/wake_combine.sv
`timescale 1ns/10ps
module wake_combine (
  input wire logic [2:0] qual,
  input wire logic combine_and,
  output logic wake
);
  always_comb begin
    wake = combine_and ? (&qual) : (|qual);
  end
endmodule
